/* logic/mpc_pkg.sv */
// Shared constants, types and helpers for the mute and pause control block
package mpc_pkg;

  // ************************************************************
  // Register bank layout
  // ************************************************************
  localparam int NUM_REGS = 10;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_INPUT = 4'h0;
  localparam logic [IDX_W-1:0] IDX_LOUD = 4'h1;
  localparam logic [IDX_W-1:0] IDX_VOLUME = 4'h2;
  localparam logic [IDX_W-1:0] IDX_TONE = 4'h3;
  localparam logic [IDX_W-1:0] IDX_SPK_LF = 4'h4;
  localparam logic [IDX_W-1:0] IDX_SPK_LR = 4'h5;
  localparam logic [IDX_W-1:0] IDX_SPK_RF = 4'h6;
  localparam logic [IDX_W-1:0] IDX_SPK_RR = 4'h7;
  localparam logic [IDX_W-1:0] IDX_MUTE = 4'h8;
  localparam logic [IDX_W-1:0] IDX_STEREO = 4'h9;
  localparam logic [IDX_W-1:0] IDX_LAST = 4'h9;

  // Subaddress byte: index in the low nibble, autoincrement flag above it
  localparam int SUB_AUTOINC_BIT = 4;

  // Bus address of the device; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h44;

  // ************************************************************
  // Field values and reset values
  // ************************************************************
  localparam logic [7:0] SPK_MUTE_CODE = 8'hff;
  localparam int NB_MODE_BIT = 5;
  localparam logic [7:0] RST_MUTE = 8'hf8;
  localparam logic [7:0] RST_NB_LR = 8'he0;
  localparam logic [7:0] RST_NB_RF = 8'he0;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Status readback bit positions, others read zero
  localparam int STAT_PILOT = 0;
  localparam int STAT_SOFT = 1;
  localparam int STAT_ZC = 2;
  localparam int STAT_PAUSE = 3;

  // ************************************************************
  // Bit-level bus framing and timing
  // ************************************************************
  localparam logic [3:0] BIT_LAST = 4'd7;
  localparam logic [3:0] BIT_ACK = 4'd8;
  localparam int CLK_MHZ = 250;
  localparam int PAUSE_TIME_NS = 360000;
  localparam int PAUSE_CYCLES = PAUSE_TIME_NS * CLK_MHZ / 1000;
  localparam int PAUSE_CNT_W = 17;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic bass_sym;
    logic [1:0] win_sel;
    logic det_reset;
    logic direct_mute;
    logic zc_req;
    logic fast_slope;
    logic soft_mute;
  } mpc_mute_t;

  typedef struct packed {
    logic blend_fade;
    logic both_all_fs;
    logic mpx_path_en;
    logic level_hp_bypass;
  } mpc_nb_t;

  typedef logic [NUM_REGS-1:0][7:0] mpc_bank_t;

  // Reset value of a bank entry
  function automatic logic [7:0] reset_value(input logic [IDX_W-1:0] idx);
    logic [7:0] val;
    val = RST_OTHER;
    if (idx == IDX_MUTE)
      val = RST_MUTE;
    else if (idx == IDX_SPK_LR)
      val = RST_NB_LR;
    else if (idx == IDX_SPK_RF)
      val = RST_NB_RF;
    return val;
  endfunction : reset_value

  // Speaker byte holds the all-ones mute code
  function automatic logic is_mute_code(input logic [7:0] b);
    return b == SPK_MUTE_CODE;
  endfunction : is_mute_code

endpackage : mpc_pkg

/* logic/mpc_cfg_bank.sv */
// Control register bank with one write port and registered contents
`timescale 1ns/100ps
`default_nettype none

module mpc_cfg_bank
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [mpc_pkg::IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  output mpc_pkg::mpc_bank_t bank
);

  // ************************************************************
  // Storage
  // ************************************************************
  mpc_pkg::mpc_bank_t bank_reg;
  logic wr_hit;

  // Indexes past the last byte are dropped
  assign wr_hit = wr_en && (wr_idx <= mpc_pkg::IDX_LAST);
  assign bank = bank_reg;

  // Reset load and byte write
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < mpc_pkg::NUM_REGS; i++)
        bank_reg[i] <= mpc_pkg::reset_value(mpc_pkg::IDX_W'(i));
    end
    else if (wr_hit)
      bank_reg[wr_idx] <= wr_data;
  end

endmodule : mpc_cfg_bank

`default_nettype wire

/* logic/mpc_top.sv */
// Bus slave, mute control, zero-crossing mute and pause detector
//
// Functional notes
// - Mute byte bit 0 turns soft mute ramp on, clear releases it.
// - Mute byte bit 1 picks fast slope when set, slow when clear.
// - Low level on phone ground input also forces soft mute.
// - Soft mute flag reads 1 immediately once requested, 0 when off.
// - Mute byte bit 3 grounds signal ahead of volume stage at once.
// - All-ones speaker byte mutes only that one output.
// - With bit 4 clear, bit 2 requests zero-cross mute or unmute.
// - Zero-cross mute changes wait until the waveform nears reference.
// - Left and right zero-cross mute states are tracked separately.
// - Bits 6:5 select detection window 160, 80, 40 or 20 mV.
// - Pending change applies when that channel reports inside window.
// - Bit 4 set holds zero-cross and pause detectors in reset.
// - Zero-cross mute flag reads 1 while that mute is in effect.
// - Pause detector uses the same window selection bits.
// - Integrator clears outside window, counts inside, pause past threshold.
// - Pause flag reads 0 during pause, 1 otherwise.
// - Stereo flag reads 1 for stereo broadcast, 0 for mono.
// - Bit 7 selects symmetrical bass; clear changes only cut settings.
// - Blend on fades detection level to multiplex; off uses both everywhere.
// - External input mode disables multiplex path, bypasses level high-pass.
// - Subaddress autoincrement flag advances index after each data byte.
// - Ten writable control bytes, each at its own subaddress.
// - Index wraps modulo sixteen; bytes at unused indexes are dropped.
// - Start is ignored until an open transaction ends with stop.
// - Status byte sent MSB first; master ack repeats, nack ends.
// - Reset mute byte: direct mute, soft off, detector reset, window 11.
`timescale 1ns/100ps
`default_nettype none

module mpc_top
#(
  parameter int PAUSE_CYCLES = mpc_pkg::PAUSE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic phone_gnd_n,
  input wire logic win_inside_l,
  input wire logic win_inside_r,
  input wire logic pilot_found,
  output logic soft_mute_on,
  output logic soft_mute_fast,
  output logic direct_mute,
  output logic [3:0] spk_mute,
  output logic zc_mute_l,
  output logic zc_mute_r,
  output logic [1:0] win_sel,
  output logic det_reset,
  output logic pause_active,
  output logic bass_sym,
  output mpc_pkg::mpc_nb_t nb_ctrl,
  output mpc_pkg::mpc_bank_t cfg_bytes
);

  // ************************************************************
  // Bus line edges and conditions
  // ************************************************************
  typedef enum logic [2:0] {
    MPC_IDLE,
    MPC_ADDR,
    MPC_SUB,
    MPC_WDAT,
    MPC_RDAT,
    MPC_HOLD
  } mpc_state_t;

  mpc_state_t state_reg;
  mpc_state_t state_next;
  logic scl_reg;
  logic sda_reg;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic rw_reg;
  logic rw_next;
  logic ack_reg;
  logic ack_next;
  logic mack_reg;
  logic [mpc_pkg::IDX_W-1:0] idx_reg;
  logic [mpc_pkg::IDX_W-1:0] idx_next;
  logic autoinc_reg;
  logic autoinc_next;
  logic wr_en;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic ack_done;
  logic rx_phase;
  logic addr_match;
  logic [7:0] status_byte;
  // Edge and start/stop detection against the previous sample
  assign scl_rise = scl_in && !scl_reg;
  assign scl_fall = !scl_in && scl_reg;
  assign start_seen = scl_in && scl_reg && sda_reg && !sda_in;
  assign stop_seen = scl_in && scl_reg && !sda_reg && sda_in;
  assign byte_done = scl_fall && (bit_reg == mpc_pkg::BIT_LAST);
  assign ack_done = scl_fall && (bit_reg == mpc_pkg::BIT_ACK);
  assign rx_phase = (state_reg == MPC_ADDR) || (state_reg == MPC_SUB)
                    || (state_reg == MPC_WDAT);
  assign addr_match = rx_reg[7:1] == mpc_pkg::DEV_ADDR;

  // ************************************************************
  // Transaction sequencer
  // ************************************************************
  // Next state, bit count, acknowledge and index handling
  always_comb
  begin
    state_next = state_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rw_next = rw_reg;
    ack_next = ack_reg;
    idx_next = idx_reg;
    autoinc_next = autoinc_reg;
    wr_en = 1'b0;
    if (stop_seen)
    begin
      state_next = MPC_IDLE;
      ack_next = 1'b0;
    end
    else if (start_seen && state_reg == MPC_IDLE)
    begin
      state_next = MPC_ADDR;
      bit_next = '1; // Start's own clock fall wraps this to zero
    end
    else if (state_reg != MPC_IDLE && state_reg != MPC_HOLD && scl_fall)
    begin
      bit_next = bit_reg + 4'd1;
      if (byte_done && rx_phase)
      begin
        ack_next = 1'b1;
        unique case (state_reg)
          MPC_ADDR:
          begin
            rw_next = rx_reg[0];
            if (!addr_match)
            begin
              ack_next = 1'b0;
              state_next = MPC_HOLD;
            end
          end
          MPC_SUB:
          begin
            idx_next = rx_reg[mpc_pkg::IDX_W-1:0];
            autoinc_next = rx_reg[mpc_pkg::SUB_AUTOINC_BIT];
          end
          MPC_WDAT:
          begin
            wr_en = 1'b1;
            if (autoinc_reg)
              idx_next = idx_reg + 4'd1;
          end
        endcase
      end
      else if (state_reg == MPC_RDAT && bit_reg < mpc_pkg::BIT_LAST)
        tx_next = {tx_reg[6:0], 1'b0};
      else if (ack_done)
      begin
        bit_next = 4'd0;
        ack_next = 1'b0;
        unique case (state_reg)
          MPC_ADDR:
          begin
            state_next = rw_reg ? MPC_RDAT : MPC_SUB;
            tx_next = status_byte;
          end
          MPC_SUB:
            state_next = MPC_WDAT;
          MPC_WDAT:
            state_next = MPC_WDAT;
          MPC_RDAT:
          begin
            tx_next = status_byte;
            if (!mack_reg)
              state_next = MPC_HOLD;
          end
          default:
            state_next = MPC_HOLD;
        endcase
      end
    end
  end

  // Sequencer registers and line samples
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      scl_reg <= 1'b1; // Idle line levels, no false edge after reset
      sda_reg <= 1'b1;
      state_reg <= MPC_IDLE;
      bit_reg <= 4'd0;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_reg <= 1'b0;
      idx_reg <= mpc_pkg::IDX_INPUT;
      autoinc_reg <= 1'b0;
    end
    else
    begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
      state_reg <= state_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rw_reg <= rw_next;
      ack_reg <= ack_next;
      idx_reg <= idx_next;
      autoinc_reg <= autoinc_next;
    end
  end
  // Received bits and the master's acknowledge on read
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_reg <= 8'h00;
      mack_reg <= 1'b0;
    end
    else if (scl_rise && rx_phase && bit_reg <= mpc_pkg::BIT_LAST)
      rx_reg <= {rx_reg[6:0], sda_in};
    else if (scl_rise && state_reg == MPC_RDAT && bit_reg == mpc_pkg::BIT_ACK)
      mack_reg <= !sda_in;
  end
  // Open-drain data line: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = !(ack_reg || (state_reg == MPC_RDAT
                     && bit_reg <= mpc_pkg::BIT_LAST && !tx_reg[7]));

  // ************************************************************
  // Control byte storage
  // ************************************************************
  mpc_pkg::mpc_bank_t bank;
  mpc_pkg::mpc_mute_t mute;
  logic [7:0] nb_lr;
  logic [7:0] nb_rf;
  mpc_cfg_bank u_bank
  (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_en),
    .wr_idx(idx_reg),
    .wr_data(rx_reg),
    .bank(bank)
  );
  // Field views of the stored bytes
  assign cfg_bytes = bank;
  assign mute = mpc_pkg::mpc_mute_t'(bank[mpc_pkg::IDX_MUTE]);
  assign nb_lr = bank[mpc_pkg::IDX_SPK_LR];
  assign nb_rf = bank[mpc_pkg::IDX_SPK_RF];

  // ************************************************************
  // Mute, speaker and noise blanker controls
  // ************************************************************
  // Soft and direct mute, slope and bass symmetry
  assign soft_mute_on = mute.soft_mute || !phone_gnd_n;
  assign soft_mute_fast = mute.fast_slope;
  assign direct_mute = mute.direct_mute;
  assign bass_sym = mute.bass_sym;
  assign win_sel = mute.win_sel;
  assign det_reset = mute.det_reset;
  // Per-output speaker mute on the all-ones code
  assign spk_mute[0] = mpc_pkg::is_mute_code(bank[mpc_pkg::IDX_SPK_LF]);
  assign spk_mute[1] = mpc_pkg::is_mute_code(bank[mpc_pkg::IDX_SPK_LR]);
  assign spk_mute[2] = mpc_pkg::is_mute_code(bank[mpc_pkg::IDX_SPK_RF]);
  assign spk_mute[3] = mpc_pkg::is_mute_code(bank[mpc_pkg::IDX_SPK_RR]);
  // Spike trigger source selection
  assign nb_ctrl.blend_fade = !nb_rf[mpc_pkg::NB_MODE_BIT];
  assign nb_ctrl.both_all_fs = nb_rf[mpc_pkg::NB_MODE_BIT];
  assign nb_ctrl.mpx_path_en = nb_lr[mpc_pkg::NB_MODE_BIT];
  assign nb_ctrl.level_hp_bypass = !nb_lr[mpc_pkg::NB_MODE_BIT];

  // ************************************************************
  // Zero-crossing mute and pause detector
  // ************************************************************
  logic zc_l_reg;
  logic zc_r_reg;
  logic [mpc_pkg::PAUSE_CNT_W-1:0] pause_cnt_reg;
  logic both_inside;

  // Each channel adopts the request only while inside the window
  always_ff @(posedge clock)
  begin
    if (rst || mute.det_reset)
    begin
      zc_l_reg <= 1'b0;
      zc_r_reg <= 1'b0;
    end
    else
    begin
      if (win_inside_l)
        zc_l_reg <= mute.zc_req;
      if (win_inside_r)
        zc_r_reg <= mute.zc_req;
    end
  end
  assign zc_mute_l = zc_l_reg;
  assign zc_mute_r = zc_r_reg;
  // Integrator: cleared outside the window, saturating count inside
  assign both_inside = win_inside_l && win_inside_r;
  assign pause_active = pause_cnt_reg >= mpc_pkg::PAUSE_CNT_W'(PAUSE_CYCLES);
  always_ff @(posedge clock)
  begin
    if (rst || mute.det_reset || !both_inside)
      pause_cnt_reg <= '0;
    else if (!pause_active)
      pause_cnt_reg <= pause_cnt_reg + 1'b1;
  end

  // ************************************************************
  // Status readback byte
  // ************************************************************
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[mpc_pkg::STAT_PILOT] = pilot_found;
    status_byte[mpc_pkg::STAT_SOFT] = soft_mute_on;
    status_byte[mpc_pkg::STAT_ZC] = zc_l_reg || zc_r_reg;
    status_byte[mpc_pkg::STAT_PAUSE] = !pause_active;
  end

endmodule : mpc_top

`default_nettype wire

/* tb/mpc_top_sva.sv */
// Port checker for the mute and pause control block
`timescale 1ns/100ps
`default_nettype none
module mpc_top_sva
#(
  parameter int PAUSE_CYCLES = 8
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic phone_gnd_n,
  input wire logic win_inside_l,
  input wire logic win_inside_r,
  input wire logic soft_mute_on,
  input wire logic soft_mute_fast,
  input wire logic direct_mute,
  input wire logic [3:0] spk_mute,
  input wire logic zc_mute_l,
  input wire logic zc_mute_r,
  input wire logic [1:0] win_sel,
  input wire logic det_reset,
  input wire logic pause_active,
  input wire logic bass_sym,
  input wire mpc_pkg::mpc_nb_t nb_ctrl,
  input wire mpc_pkg::mpc_bank_t cfg_bytes
);
  // ******************
  // Properties
  // ******************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] mb;
  int quiet_reg;
  assign mb = cfg_bytes[8];
  // Counts cycles with both channels quiet
  always_ff @(posedge clock)
  begin
    if (rst || det_reset || !(win_inside_l && win_inside_r))
      quiet_reg <= 0;
    else if (quiet_reg < PAUSE_CYCLES)
      quiet_reg <= quiet_reg + 1;
  end
  property p_soft;
    soft_mute_on == (mb[0] || !phone_gnd_n) && soft_mute_fast == mb[1];
  endproperty
  a_soft: assert property (p_soft) else $error("soft mute outputs wrong");
  property p_mute;
    direct_mute == mb[3] && bass_sym == mb[7] && win_sel == mb[6:5] && det_reset == mb[4];
  endproperty
  a_mute: assert property (p_mute) else $error("mute byte outputs wrong");
  property p_spk;
    spk_mute == {cfg_bytes[7] == 8'hff, cfg_bytes[6] == 8'hff,
                 cfg_bytes[5] == 8'hff, cfg_bytes[4] == 8'hff};
  endproperty
  a_spk: assert property (p_spk) else $error("speaker mute wrong");
  property p_nb;
    nb_ctrl == {!cfg_bytes[6][5], cfg_bytes[6][5], cfg_bytes[5][5], !cfg_bytes[5][5]};
  endproperty
  a_nb: assert property (p_nb) else $error("blanker select wrong");
  property p_zc_l;
    win_inside_l && !det_reset |=> zc_mute_l == $past(mb[2]);
  endproperty
  a_zc_l: assert property (p_zc_l) else $error("left zero mute missed");
  property p_zc_r;
    win_inside_r && !det_reset |=> zc_mute_r == $past(mb[2]);
  endproperty
  a_zc_r: assert property (p_zc_r) else $error("right zero mute missed");
  property p_zc_hold;
    !win_inside_l && !det_reset |=> $stable(zc_mute_l);
  endproperty
  a_zc_hold: assert property (p_zc_hold) else $error("zero mute changed early");
  property p_det;
    det_reset |=> !zc_mute_l && !zc_mute_r && !pause_active;
  endproperty
  a_det: assert property (p_det) else $error("detector not held");
  property p_pause;
    pause_active == (quiet_reg >= PAUSE_CYCLES);
  endproperty
  a_pause: assert property (p_pause) else $error("pause timing wrong");
  property p_rst;
    $fell(rst) |-> mb == 8'hf8 && !zc_mute_l && !pause_active;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_pause: cover property ($rose(pause_active));
  c_zc: cover property (zc_mute_l && !zc_mute_r);
  c_force: cover property (!phone_gnd_n && !mb[0]);
endmodule : mpc_top_sva
bind mpc_top mpc_top_sva #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_sva (.clock(clock), .rst(rst),
  .phone_gnd_n(phone_gnd_n), .win_inside_l(win_inside_l), .win_inside_r(win_inside_r),
  .soft_mute_on(soft_mute_on), .soft_mute_fast(soft_mute_fast), .direct_mute(direct_mute),
  .spk_mute(spk_mute), .zc_mute_l(zc_mute_l), .zc_mute_r(zc_mute_r), .win_sel(win_sel),
  .det_reset(det_reset), .pause_active(pause_active), .bass_sym(bass_sym),
  .nb_ctrl(nb_ctrl), .cfg_bytes(cfg_bytes));
`default_nettype wire

/* tb/mpc_host.sv */
// Bus master model of the host controller
`timescale 1ns/100ps
`default_nettype none
module mpc_host
(
  input wire logic clock,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m,
  output logic [7:0] rd_data,
  output logic rd_stb
);
  // ******************
  // Bus phases
  // ******************
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
    rd_data = 8'h00;
    rd_stb = 1'b0;
  end
  // Read strobe stands one cycle
  always @(posedge clock)
    if (rd_stb)
      rd_stb <= 1'b0;
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt
  task automatic start_c();
    sda_m <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(3);
    sda_m <= 1'b0;
    wt(3);
    scl <= 1'b0;
    wt(2);
  endtask : start_c
  task automatic stop_c();
    sda_m <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(3);
    sda_m <= 1'b1;
    wt(4);
  endtask : stop_c
  // One clock pulse, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    r = sda_w;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask : bit_x
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // Ack asks for more, nack ends the read
  task automatic rd_byte(input logic more);
    logic r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(!more, r);
    rd_data <= d;
    rd_stb <= 1'b1;
  endtask : rd_byte
  task automatic write_seq(input logic [6:0] a, input logic [7:0] sub,
                           input logic [7:0] d[$], output logic ok);
    logic k;
    start_c();
    wr_byte({a, 1'b0}, ok);
    wr_byte(sub, k);
    ok = ok & k;
    foreach (d[i])
    begin
      wr_byte(d[i], k);
      ok = ok & k;
    end
    stop_c();
  endtask : write_seq
  task automatic read_seq(input int n);
    logic k;
    start_c();
    wr_byte({mpc_pkg::DEV_ADDR, 1'b1}, k);
    for (int i = 0; i < n; i++)
      rd_byte(i < n - 1);
    stop_c();
  endtask : read_seq
endmodule : mpc_host
`default_nettype wire

/* tb/tb_mpc_top.sv */
// Self-checking bench for the mute and pause control block
`timescale 1ns/100ps
`default_nettype none
module tb_mpc_top;
  logic clock, rst, phone_gnd_n, win_inside_l, win_inside_r, pilot_found;
  logic scl, sda_m, sda_out, sda_oe_n, rd_stb, ok;
  logic soft_mute_on, soft_mute_fast, direct_mute, zc_mute_l, zc_mute_r;
  logic det_reset, pause_active, bass_sym;
  logic [3:0] spk_mute;
  logic [1:0] win_sel;
  logic [7:0] rd_data;
  logic [15:0] lfsr;
  logic [7:0] exp_q[$];
  logic [7:0] dq[$];
  mpc_pkg::mpc_nb_t nb_ctrl;
  mpc_pkg::mpc_bank_t cfg_bytes;
  wire logic sda_w;
  int miscompares;
  int checks_done;
  // Open-drain data line with pull-up
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  mpc_top #(.PAUSE_CYCLES(8)) dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .phone_gnd_n(phone_gnd_n),
    .win_inside_l(win_inside_l), .win_inside_r(win_inside_r), .pilot_found(pilot_found),
    .soft_mute_on(soft_mute_on), .soft_mute_fast(soft_mute_fast), .direct_mute(direct_mute),
    .spk_mute(spk_mute), .zc_mute_l(zc_mute_l), .zc_mute_r(zc_mute_r), .win_sel(win_sel),
    .det_reset(det_reset), .pause_active(pause_active), .bass_sym(bass_sym),
    .nb_ctrl(nb_ctrl), .cfg_bytes(cfg_bytes));
  mpc_host host (.clock(clock), .sda_w(sda_w), .scl(scl), .sda_m(sda_m),
    .rd_data(rd_data), .rd_stb(rd_stb));
  // ******************
  // Helpers
  // ******************
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Next pseudo-random byte from the shift register
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  task automatic wr(input logic [7:0] sub);
    host.write_seq(mpc_pkg::DEV_ADDR, sub, dq, ok);
    chk(ok, 8'h01);
  endtask : wr
  task automatic rd_stat(input logic [7:0] e, input int n);
    repeat (n) exp_q.push_back(e);
    host.read_seq(n);
  endtask : rd_stat
  task automatic drv(input logic pg, input logic l, input logic r);
    @(posedge clock);
    phone_gnd_n <= pg;
    win_inside_l <= l;
    win_inside_r <= r;
    repeat (3) @(posedge clock);
  endtask : drv
  // Status bytes compared as they arrive
  always @(posedge clock)
    if (rd_stb === 1'b1)
      chk(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  initial
  begin
    repeat (80000) @(posedge clock);
    miscompares++;
    $display("MISMATCH t=%0t timeout", $time);
    report_and_stop();
  end
  // ******************
  // Scenarios
  // ******************
  initial
  begin
    logic [7:0] v;
    logic [3:0] e;
    rst = 1'b1;
    phone_gnd_n = 1'b1;
    win_inside_l = 1'b0;
    win_inside_r = 1'b0;
    pilot_found = 1'b0;
    lfsr = 16'h8920;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    v = rnd();
    pilot_found <= v[0];
    @(posedge clock);
    chk(cfg_bytes[8], 8'hf8);
    chk(nb_ctrl, 4'b0110);
    rd_stat({7'h04, v[0]}, 2);
    dq = '{8'h03};
    wr(8'h08);
    chk({soft_mute_on, soft_mute_fast, direct_mute, bass_sym}, 4'b1100);
    rd_stat({7'h05, v[0]}, 1);
    dq = '{8'h00};
    wr(8'h08);
    drv(1'b0, 1'b0, 1'b0);
    chk(soft_mute_on, 8'h01);
    drv(1'b1, 1'b0, 1'b0);
    chk({soft_mute_on, soft_mute_fast}, 8'h00);
    dq = {};
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      dq.push_back(v);
    end
    dq[2] = 8'hff;
    wr(8'h14);
    foreach (dq[i])
    begin
      chk(cfg_bytes[4 + i], dq[i]);
      e[i] = dq[i] == 8'hff;
    end
    chk(spk_mute, e);
    chk(nb_ctrl, {2'b01, dq[1][5], !dq[1][5]});
    wr(8'h1e);
    chk(cfg_bytes[0], dq[2]);
    chk(cfg_bytes[1], dq[3]);
    chk(cfg_bytes[9], 8'h00);
    wr(8'h02);
    chk(cfg_bytes[2], dq[3]);
    chk(cfg_bytes[3], 8'h00);
    v = dq[3];
    dq = '{8'h5a};
    host.write_seq(mpc_pkg::DEV_ADDR ^ 7'h01, 8'h02, dq, ok);
    chk(ok, 8'h00);
    chk(cfg_bytes[2], v);
    host.start_c();
    host.wr_byte(8'h88, ok);
    host.wr_byte(8'h03, ok);
    host.wr_byte(8'h11, ok);
    host.start_c();
    host.wr_byte(8'h88, ok);
    host.stop_c();
    chk(cfg_bytes[3], 8'hc4);
    for (int c = 0; c < 4; c++)
    begin
      dq = '{{1'b0, c[1:0], 5'b00100}};
      wr(8'h08);
      chk(win_sel, c[1:0]);
    end
    chk({zc_mute_l, zc_mute_r}, 8'h00);
    drv(1'b1, 1'b1, 1'b0);
    chk({zc_mute_l, zc_mute_r}, 2'b10);
    rd_stat({7'h06, pilot_found}, 1);
    drv(1'b1, 1'b1, 1'b1);
    for (int n = 0; n < 20 && pause_active !== 1'b1; n++)
      @(posedge clock);
    chk(pause_active, 8'h01);
    rd_stat({7'h02, pilot_found}, 1);
    drv(1'b1, 1'b0, 1'b1);
    chk(pause_active, 8'h00);
    dq = '{8'h60};
    wr(8'h08);
    chk({zc_mute_l, zc_mute_r}, 2'b10);
    dq = '{8'h74};
    wr(8'h08);
    drv(1'b1, 1'b1, 1'b1);
    repeat (12) @(posedge clock);
    chk({zc_mute_l, zc_mute_r, pause_active}, 8'h00);
    report_and_stop();
  end
endmodule : tb_mpc_top
`default_nettype wire
